// ### rtl/cmc_cmap.sv
`timescale 1ns/1ps
module cmc_cmap (
  input  wire logic                          clk_i,
  input  wire logic                          rstn_i,
  input  wire logic [cmc_pkg::CM_IDX_W-1:0]  pix_idx_i,
  output logic      [cmc_pkg::CM_VAL_W-1:0]  pix_lut_o,
  input  wire logic                          wr_en_i,
  input  wire logic [cmc_pkg::CM_IDX_W-1:0]  addr_i,
  input  wire logic [cmc_pkg::CM_VAL_W-1:0]  wdata_i,
  output logic      [cmc_pkg::CM_VAL_W-1:0]  rdata_o
);
  import cmc_pkg::*;

  logic [CM_VAL_W-1:0] mem [0:CM_DEPTH-1];

  // The pixel port and the host port read the same table independently.
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[addr_i] <= wdata_i;
    end
    if (!rstn_i) begin
      pix_lut_o <= LUT_RST;
      rdata_o   <= LUT_RST;
    end else begin
      pix_lut_o <= mem[pix_idx_i];
      rdata_o   <= mem[addr_i];
    end
  end

endmodule

// ### rtl/cmc_pkg.sv
package cmc_pkg;

  localparam int CH_N      = 3;
  localparam int CM_IDX_W  = 10;
  localparam int CM_DEPTH  = 1024;
  localparam int CM_VAL_W  = 12;
  localparam int FB_W      = 12;
  localparam int IDX_SHIFT = 2;
  localparam int OUT_W     = 13;
  localparam int CUR_DIM   = 128;
  localparam int CUR_SLOTS = 4;
  localparam int SLOT_W    = 2;
  localparam int ROW_W     = 7;
  localparam int CUR_WORDS = 512;
  localparam int CUR_AW    = 9;
  localparam int POS_W     = 11;
  localparam int CH_SEL_W  = 2;

  localparam logic [OUT_W-1:0]     SUPERWHITE = 13'h1fff;
  localparam logic [POS_W-1:0]     POS_RST    = 11'h000;
  localparam logic [SLOT_W-1:0]    SLOT_RST   = 2'h0;
  localparam logic [CM_VAL_W-1:0]  LUT_RST    = 12'h000;

  typedef enum logic [2:0] {
    MODE_RGB      = 3'b000,
    MODE_PS_RED   = 3'b001,
    MODE_PS_GREEN = 3'b010,
    MODE_PS_BLUE  = 3'b011,
    MODE_PS_ALPHA = 3'b100
  } cmc_mode_e;

  typedef enum logic [2:0] {
    OP_NONE    = 3'b000,
    OP_CM_WR   = 3'b001,
    OP_CM_RD   = 3'b010,
    OP_CUR_WR  = 3'b011,
    OP_POS     = 3'b100,
    OP_CUR_ON  = 3'b101,
    OP_CUR_OFF = 3'b110
  } cmc_op_e;

  typedef struct packed {
    logic               valid;
    logic [FB_W-1:0]    r;
    logic [FB_W-1:0]    g;
    logic [FB_W-1:0]    b;
    logic [FB_W-1:0]    a;
    logic [POS_W-1:0]   x;
    logic [POS_W-1:0]   y;
  } cmc_pix_s;

  typedef struct packed {
    logic               valid;
    logic [OUT_W-1:0]   r;
    logic [OUT_W-1:0]   g;
    logic [OUT_W-1:0]   b;
  } cmc_vid_s;

  typedef struct packed {
    cmc_op_e             op;
    logic [CH_SEL_W-1:0] chan;
    logic [CM_IDX_W-1:0] index;
    logic [CM_VAL_W-1:0] data;
    logic [SLOT_W-1:0]   slot;
    logic [ROW_W-1:0]    row;
    logic [CUR_DIM-1:0]  bits;
    logic [POS_W-1:0]    x;
    logic [POS_W-1:0]    y;
  } cmc_cmd_s;

endpackage

// ### rtl/cmc_top.sv
`timescale 1ns/1ps
module cmc_top (
  input  wire logic                         CLK_I,
  input  wire logic                         RSTN_I,
  input  wire cmc_pkg::cmc_pix_s            PIX_I,
  input  wire cmc_pkg::cmc_mode_e           MODE_I,
  input  wire logic                         DEPTH8_I,
  input  wire cmc_pkg::cmc_cmd_s            CMD_I,
  output cmc_pkg::cmc_vid_s                 VID_O,
  output logic                              RD_VALID_O,
  output logic      [cmc_pkg::CM_VAL_W-1:0] RD_DATA_O,
  output logic                              CUR_ON_O,
  output logic      [cmc_pkg::SLOT_W-1:0]   CUR_SLOT_O
);
  import cmc_pkg::*;

  // Forms the table index from one framebuffer sample.
  function automatic logic [CM_IDX_W-1:0] idx_of(
    input logic [FB_W-1:0] s,
    input logic            d8
  );
    if (d8) begin
      idx_of = {s[CM_IDX_W-IDX_SHIFT-1:0], {IDX_SHIFT{1'b0}}};
    end else begin
      idx_of = s[FB_W-1:IDX_SHIFT];
    end
  endfunction

  // Crossbar: picks the source sample for one output table.
  function automatic logic [FB_W-1:0] src_of(
    input cmc_pix_s             p,
    input cmc_mode_e            m,
    input logic [CH_SEL_W-1:0]  ch
  );
    case (m)
      MODE_PS_RED:   src_of = p.r;
      MODE_PS_GREEN: src_of = p.g;
      MODE_PS_BLUE:  src_of = p.b;
      MODE_PS_ALPHA: src_of = p.a;
      default: begin
        case (ch)
          2'h0:    src_of = p.r;
          2'h1:    src_of = p.g;
          default: src_of = p.b;
        endcase
      end
    endcase
  endfunction

  // True when the host command of this cycle carries the given operation.
  function automatic logic op_is(
    input cmc_cmd_s cmd,
    input cmc_op_e  op
  );
    op_is = (cmd.op == op);
  endfunction

  // Picks the read-back word of one table; a missing table reads as zero.
  function automatic logic [CM_VAL_W-1:0] rd_pick(
    input logic [CH_N-1:0][CM_VAL_W-1:0] words,
    input logic [CH_SEL_W-1:0]           ch
  );
    if (ch < CH_SEL_W'(CH_N)) begin
      rd_pick = words[ch];
    end else begin
      rd_pick = LUT_RST;
    end
  endfunction

  // Cursor control state.
  logic [POS_W-1:0]      pos_x_q;
  logic [POS_W-1:0]      pos_x_d;
  logic [POS_W-1:0]      pos_y_q;
  logic [POS_W-1:0]      pos_y_d;
  logic [SLOT_W-1:0]     slot_q;
  logic [SLOT_W-1:0]     slot_d;
  logic                  en_q;
  logic                  en_d;
  logic [CUR_SLOTS-1:0]  loaded_q;
  logic [CUR_SLOTS-1:0]  loaded_d;

  // First pipeline stage: indices and cursor window test.
  logic [POS_W-1:0]                 dx;
  logic [POS_W-1:0]                 dy;
  logic                             in_x;
  logic                             in_y;
  logic                             a_valid_q;
  logic                             a_valid_d;
  logic                             a_hit_q;
  logic                             a_hit_d;
  logic [ROW_W-1:0]                 a_col_q;
  logic [ROW_W-1:0]                 a_col_d;
  logic [CUR_AW-1:0]                a_raddr_q;
  logic [CUR_AW-1:0]                a_raddr_d;
  logic [CH_N-1:0][CM_IDX_W-1:0]    a_idx_q;
  logic [CH_N-1:0][CM_IDX_W-1:0]    a_idx_d;

  // Second pipeline stage: table outputs and cursor row.
  logic                             b_valid_q;
  logic                             b_valid_d;
  logic                             b_hit_q;
  logic                             b_hit_d;
  logic [ROW_W-1:0]                 b_col_q;
  logic [ROW_W-1:0]                 b_col_d;
  logic [CUR_DIM-1:0]               b_row_q;
  logic [CH_N-1:0][CM_VAL_W-1:0]    lut;
  logic [CH_N-1:0][CM_VAL_W-1:0]    cm_rdata;

  // Output stage and host read path.
  cmc_vid_s                         vid_q;
  cmc_vid_s                         vid_d;
  logic                             cur_bit;
  logic                             rd_p_q;
  logic                             rd_p_d;
  logic [CH_SEL_W-1:0]              rd_ch_q;
  logic [CH_SEL_W-1:0]              rd_ch_d;
  logic                             rd_v_q;
  logic                             rd_v_d;
  logic [CM_VAL_W-1:0]              rd_q;
  logic [CM_VAL_W-1:0]              rd_d;

  logic [CUR_DIM-1:0]               cur_mem [0:CUR_WORDS-1];

  // Control registers follow the host commands, except OP_POS while no cursor slot is loaded.
  always_comb begin
    pos_x_d  = pos_x_q;
    pos_y_d  = pos_y_q;
    slot_d   = slot_q;
    en_d     = en_q;
    loaded_d = loaded_q;
    case (CMD_I.op)
      OP_CUR_WR: begin
        loaded_d[CMD_I.slot] = 1'b1;
      end
      OP_POS: begin
        if (|loaded_q) begin
          pos_x_d = CMD_I.x;
          pos_y_d = CMD_I.y;
        end
      end
      OP_CUR_ON: begin
        slot_d = CMD_I.slot;
        en_d   = 1'b1;
      end
      OP_CUR_OFF: begin
        en_d = 1'b0;
      end
      default: begin
        en_d = en_q;
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      pos_x_q  <= POS_RST;
      pos_y_q  <= POS_RST;
      slot_q   <= SLOT_RST;
      en_q     <= 1'b0;
      loaded_q <= '0;
    end else begin
      pos_x_q  <= pos_x_d;
      pos_y_q  <= pos_y_d;
      slot_q   <= slot_d;
      en_q     <= en_d;
      loaded_q <= loaded_d;
    end
  end

  // The cursor window is the square that starts at the cursor position.
  always_comb begin
    dx        = PIX_I.x - pos_x_q;
    dy        = PIX_I.y - pos_y_q;
    in_x      = (dx < POS_W'(CUR_DIM));
    in_y      = (dy < POS_W'(CUR_DIM));
    a_valid_d = PIX_I.valid;
    a_hit_d   = en_q && in_x && in_y;
    a_col_d   = dx[ROW_W-1:0];
    a_raddr_d = {slot_q, dy[ROW_W-1:0]};
    for (int c = 0; c < CH_N; c++) begin
      a_idx_d[c] = idx_of(src_of(PIX_I, MODE_I, CH_SEL_W'(c)),
                          DEPTH8_I);
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      a_valid_q <= 1'b0;
      a_hit_q   <= 1'b0;
      a_col_q   <= '0;
      a_raddr_q <= '0;
      a_idx_q   <= '0;
    end else begin
      a_valid_q <= a_valid_d;
      a_hit_q   <= a_hit_d;
      a_col_q   <= a_col_d;
      a_raddr_q <= a_raddr_d;
      a_idx_q   <= a_idx_d;
    end
  end

  genvar gc;
  generate
    for (gc = 0; gc < CH_N; gc++) begin : g_cmap
      cmc_cmap u_cmap (
        .clk_i     (CLK_I),
        .rstn_i    (RSTN_I),
        .pix_idx_i (a_idx_q[gc]),
        .pix_lut_o (lut[gc]),
        .wr_en_i   (op_is(CMD_I, OP_CM_WR) &&
                    (CMD_I.chan == CH_SEL_W'(gc))),
        .addr_i    (CMD_I.index),
        .wdata_i   (CMD_I.data),
        .rdata_o   (cm_rdata[gc])
      );
    end
  endgenerate

  // Cursor masks live in their own store, apart from the framebuffer.
  always_ff @(posedge CLK_I) begin
    if (op_is(CMD_I, OP_CUR_WR)) begin
      cur_mem[{CMD_I.slot, CMD_I.row}] <= CMD_I.bits;
    end
    if (!RSTN_I) begin
      b_row_q <= '0;
    end else begin
      b_row_q <= cur_mem[a_raddr_q];
    end
  end

  always_comb begin
    b_valid_d = a_valid_q;
    b_hit_d   = a_hit_q;
    b_col_d   = a_col_q;
  end

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      b_valid_q <= 1'b0;
      b_hit_q   <= 1'b0;
      b_col_q   <= '0;
    end else begin
      b_valid_q <= b_valid_d;
      b_hit_q   <= b_hit_d;
      b_col_q   <= b_col_d;
    end
  end

  // Table values pass as they are; only a set cursor bit replaces them.
  always_comb begin
    cur_bit     = b_hit_q && b_row_q[b_col_q];
    vid_d.valid = b_valid_q;
    if (cur_bit) begin
      vid_d.r = SUPERWHITE;
      vid_d.g = SUPERWHITE;
      vid_d.b = SUPERWHITE;
    end else begin
      vid_d.r = {1'b0, lut[0]};
      vid_d.g = {1'b0, lut[1]};
      vid_d.b = {1'b0, lut[2]};
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      vid_q <= '0;
    end else begin
      vid_q <= vid_d;
    end
  end

  // Host read-back returns two cycles after the command.
  always_comb begin
    rd_p_d  = op_is(CMD_I, OP_CM_RD);
    rd_ch_d = CMD_I.chan;
    rd_v_d  = rd_p_q;
    rd_d    = rd_q;
    if (rd_p_q) begin
      rd_d = rd_pick(cm_rdata, rd_ch_q);
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      rd_p_q  <= 1'b0;
      rd_ch_q <= '0;
      rd_v_q  <= 1'b0;
      rd_q    <= LUT_RST;
    end else begin
      rd_p_q  <= rd_p_d;
      rd_ch_q <= rd_ch_d;
      rd_v_q  <= rd_v_d;
      rd_q    <= rd_d;
    end
  end

  assign VID_O      = vid_q;
  assign RD_VALID_O = rd_v_q;
  assign RD_DATA_O  = rd_q;
  assign CUR_ON_O   = en_q;
  assign CUR_SLOT_O = slot_q;

endmodule

// ### tb/cmc_fb_model.sv
`timescale 1ns/1ps
module cmc_fb_model (
  input  wire logic        clk_i,
  output cmc_pkg::cmc_pix_s pix_o
);
  import cmc_pkg::*;
  initial pix_o = '0;
  // Shows one pixel for one cycle, then scrambles the released lines.
  task automatic show(input logic [FB_W-1:0] r, g, b, a,
                      input logic [POS_W-1:0] x, y);
    cmc_pix_s idle;
    @(negedge clk_i);
    pix_o = '{1'b1, r, g, b, a, x, y};
    @(negedge clk_i);
    idle = ~pix_o;
    idle.valid = 1'b0;
    pix_o = idle;
  endtask
endmodule

// ### tb/cmc_props.sv
`timescale 1ns/1ps
module cmc_props
  import cmc_pkg::*;
(
  input wire logic                         CLK_I,
  input wire logic                         RSTN_I,
  input wire cmc_pkg::cmc_pix_s            PIX_I,
  input wire cmc_pkg::cmc_mode_e           MODE_I,
  input wire logic                         DEPTH8_I,
  input wire cmc_pkg::cmc_cmd_s            CMD_I,
  input wire cmc_pkg::cmc_vid_s            VID_O,
  input wire logic                         RD_VALID_O,
  input wire logic      [cmc_pkg::CM_VAL_W-1:0] RD_DATA_O,
  input wire logic                         CUR_ON_O,
  input wire logic      [cmc_pkg::SLOT_W-1:0]   CUR_SLOT_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RSTN_I);
  sequence s_rd_req;
    CMD_I.op == OP_CM_RD;
  endsequence
  sequence s_cur_quiet;
    !CUR_ON_O [*4] ##0 VID_O.valid;
  endsequence
  a_vid_latency: assert property ($past(RSTN_I, 3) |->
    VID_O.valid == $past(PIX_I.valid, 3)) else $error("video latency");
  a_rd_answer: assert property (s_rd_req |-> ##2 RD_VALID_O)
    else $error("read answer missing");
  a_rd_only: assert property (RD_VALID_O |->
    $past(CMD_I.op, 2) == OP_CM_RD) else $error("stray read pulse");
  a_cur_on: assert property (CMD_I.op == OP_CUR_ON |=>
    CUR_ON_O && CUR_SLOT_O == $past(CMD_I.slot)) else $error("cursor on");
  a_cur_off: assert property (CMD_I.op == OP_CUR_OFF |=> !CUR_ON_O)
    else $error("cursor off");
  a_cur_steady: assert property (!(CMD_I.op inside {OP_CUR_ON,
    OP_CUR_OFF}) |=> $stable(CUR_ON_O)) else $error("cursor flag moved");
  a_quiet_pass: assert property (s_cur_quiet |-> VID_O.r <= 13'h0fff &&
    VID_O.g <= 13'h0fff && VID_O.b <= 13'h0fff) else $error("overlay shown");
  a_sw_all: assert property (VID_O.r == SUPERWHITE |->
    VID_O.g == SUPERWHITE && VID_O.b == SUPERWHITE) else $error("partial");
endmodule

// ### tb/colormap_and_cursor_overlay_bench.sv
`timescale 1ns/1ps
module colormap_and_cursor_overlay_bench;
  import cmc_pkg::*;
  localparam logic [38:0] BASE = {13'h0123, 13'h0246, 13'h0369};
  localparam logic [38:0] SW3  = {3{SUPERWHITE}};
  logic      clk = 1'b0;
  logic      rstn = 1'b0;
  cmc_mode_e mode = MODE_RGB;
  logic      d8 = 1'b0;
  cmc_cmd_s  cmd = '0;
  cmc_pix_s  pix;
  cmc_vid_s  vid;
  logic      rd_v;
  logic      [CM_VAL_W-1:0] rd_d;
  logic      cur_on;
  logic      [SLOT_W-1:0] cur_slot;
  int        n_errors = 0;
  int        num_checks = 0;
  always #25 clk = ~clk;
  cmc_fb_model fb (.clk_i(clk), .pix_o(pix));
  cmc_top uut (.CLK_I(clk), .RSTN_I(rstn), .PIX_I(pix), .MODE_I(mode),
    .DEPTH8_I(d8), .CMD_I(cmd), .VID_O(vid), .RD_VALID_O(rd_v),
    .RD_DATA_O(rd_d), .CUR_ON_O(cur_on), .CUR_SLOT_O(cur_slot));
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [38:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic go(input cmc_op_e op, input logic [1:0] s,
                    input logic [10:0] a, input logic [11:0] d,
                    input logic [127:0] bits);
    @(negedge clk);
    cmd = '{op, s, a[9:0], d, s, a[6:0], bits, a, d[10:0]};
    @(negedge clk);
    cmd = '0;
  endtask
  task automatic wait_for(input bit on_vid);
    for (int i = 0; i < 8 && (on_vid ? vid.valid : rd_v) !== 1'b1; i++) begin
      @(negedge clk);
    end
    if ((on_vid ? vid.valid : rd_v) !== 1'b1) begin
      n_errors++;
      complete_run();
    end
  endtask
  task automatic rd(input logic [1:0] ch, input logic [11:0] exp);
    go(OP_CM_RD, ch, 11'h004, 12'h000, '0);
    wait_for(1'b0);
    chk("read", {27'h0, rd_d}, {27'h0, exp});
  endtask
  task automatic px(input logic [11:0] r, g, b, a, input logic [10:0] x, y,
                    input logic [38:0] exp);
    fb.show(r, g, b, a, x, y);
    wait_for(1'b1);
    chk("video", {vid.r, vid.g, vid.b}, exp);
  endtask
  task automatic t_tables();
    for (int c = 0; c < 3; c++) begin
      go(OP_CM_WR, 2'(c), 11'h004, BASE[37-13*c -: 12], '0);
    end
    go(OP_CM_WR, 2'h0, 11'h3ff, 12'hfff, '0);
    go(OP_CM_WR, 2'h3, 11'h004, 12'habc, '0);
    for (int c = 0; c < 3; c++) begin
      rd(2'(c), BASE[37-13*c -: 12]);
    end
    rd(2'h3, 12'h000);
  endtask
  task automatic t_lookup();
    px(12'h013, 12'h012, 12'h010, 12'h0, 11'h7f0, 11'h7f0, BASE);
    d8 = 1'b1;
    px(12'h001, 12'h001, 12'h001, 12'h0, 11'h7f0, 11'h7f0, BASE);
    d8 = 1'b0;
    px(12'hfff, 12'h010, 12'h010, 12'h0, 11'h7f0, 11'h7f0,
       {13'h0fff, BASE[25:0]});
    for (int m = 1; m < 5; m++) begin
      mode = cmc_mode_e'(m);
      px(m == 1 ? 12'h010 : 12'h0, m == 2 ? 12'h010 : 12'h0,
         m == 3 ? 12'h010 : 12'h0, m == 4 ? 12'h010 : 12'h0,
         11'h7f0, 11'h7f0, BASE);
    end
    mode = MODE_RGB;
  endtask
  task automatic cp(input logic [10:0] x, y, input logic [38:0] exp);
    px(12'h010, 12'h010, 12'h010, 12'h0, x, y, exp);
  endtask
  task automatic t_cursor();
    go(OP_POS, 2'h0, 11'h064, 12'h005, '0);
    go(OP_CUR_WR, 2'h2, 11'h000, 12'h000, 128'h1);
    go(OP_CUR_ON, 2'h2, 11'h000, 12'h000, '0);
    chk("slot", {36'h0, cur_on, cur_slot}, {36'h0, 3'b110});
    cp(11'h000, 11'h000, SW3);
    cp(11'h001, 11'h000, BASE);
    go(OP_POS, 2'h0, 11'h00a, 12'h014, '0);
    cp(11'h00a, 11'h014, SW3);
    cp(11'h009, 11'h014, BASE);
    go(OP_CUR_OFF, 2'h0, 11'h000, 12'h000, '0);
    cp(11'h00a, 11'h014, BASE);
    go(OP_CUR_WR, 2'h1, 11'h000, 12'h000, 128'h2);
    go(OP_CUR_ON, 2'h1, 11'h000, 12'h000, '0);
    cp(11'h00b, 11'h014, SW3);
    cp(11'h00a, 11'h014, BASE);
    go(OP_CUR_ON, 2'h2, 11'h000, 12'h000, '0);
    cp(11'h00a, 11'h014, SW3);
  endtask
  task automatic t_linear();
    logic [11:0] v;
    for (int i = 0; i < 1024; i++) begin
      if (i < 512) begin
        v = 12'((i * 4095) / 511);
      end else if (i < 768) begin
        v = 12'hfff;
      end else begin
        v = 12'h000;
      end
      go(OP_CM_WR, 2'h0, 11'(i), v, '0);
    end
    px(12'hc00, 12'h010, 12'h010, 12'h0, 11'h7f0, 11'h7f0,
       {13'h0000, BASE[25:0]});
    px(12'h800, 12'h010, 12'h010, 12'h0, 11'h7f0, 11'h7f0,
       {13'h0fff, BASE[25:0]});
    px(12'h400, 12'h010, 12'h010, 12'h0, 11'h7f0, 11'h7f0,
       {13'h0803, BASE[25:0]});
    rd(2'h0, 12'h020);
  endtask
  initial begin
    repeat (4) @(negedge clk);
    chk("reset video", {vid.r, vid.g, vid.b}, '0);
    chk("reset flags", {22'h0, vid.valid, cur_on, rd_v, cur_slot, rd_d}, '0);
    rstn = 1'b1;
    t_tables();
    t_lookup();
    t_cursor();
    t_linear();
    complete_run();
  end
  initial begin
    #2ms;
    n_errors++;
    complete_run();
  end
endmodule
bind cmc_top cmc_props u_props (.CLK_I(CLK_I), .RSTN_I(RSTN_I),
  .PIX_I(PIX_I), .MODE_I(MODE_I), .DEPTH8_I(DEPTH8_I), .CMD_I(CMD_I),
  .VID_O(VID_O), .RD_VALID_O(RD_VALID_O), .RD_DATA_O(RD_DATA_O),
  .CUR_ON_O(CUR_ON_O), .CUR_SLOT_O(CUR_SLOT_O));
